// File: rtl/uart_flow_defs.svh
`ifndef UART_FLOW_DEFS_SVH
`define UART_FLOW_DEFS_SVH
// register byte offsets
`define OFS_LINE_CTRL 8'h00
`define OFS_FIFO_CTRL 8'h04
`define OFS_TX_DATA 8'h08
`define OFS_SAMPLE_DIV 8'h0c
`define OFS_STATUS 8'h10
// line control fields
`define LC_CTS_EN 9
`define LC_RTS_EN 8
`define LC_BREAK 6
`define LC_RW_MASK 32'h0000_037f
`define LC_RESET 32'h0000_0003
// fifo control trigger field
`define FC_TRIG_HI 7
`define FC_TRIG_LO 6
// sampling ticks within one bit and start qualification points
`define TICK_LAST 4'hf
`define QUAL_FIRST 4'h7
`define QUAL_LAST 4'h9
`define RX_STOP_BIT 4'h9
// watermark rows, by trigger setting
`define HWM_T1 6'h08
`define LWM_T1 6'h01
`define HWM_T8 6'h10
`define LWM_T8 6'h04
`define HWM_T16 6'h18
`define LWM_T16 6'h08
`define HWM_T24 6'h1c
`define LWM_T24 6'h10
// status fields
`define ST_RTS 21
`define ST_TXBUSY 20
`define TX_FIFO_DEPTH 8
`endif

// File: rtl/uart_flow_pkg.sv
package uart_flow_pkg;
  // avalon request from the bus master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } avm_req_t;
  // start qualification states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_QUAL = 3'b010,
    RX_FRAME = 3'b100
  } rx_state_t;
  // transmitter states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;
endpackage : uart_flow_pkg

// File: rtl/uart_rx_start_and_flow_ctrl.sv
// Notes on behaviour
// - idle serial line rests high
// - first falling edge on idle line starts qualification
// - start bit low, stop bits high
// - sample line at ticks seven, eight, nine
// - two of three low accepts start
// - otherwise discard edge, wait again
// - cts enable set: halt while cts high
// - cts enable clear: send regardless of cts
// - rts enable: reassert below low watermark
// - rts disabled: level does not steer rts
// - watermark pairs follow receive trigger setting
// - line control bit 6 requests break
// - break holds tx low while set
// - two-bit trigger field picks watermark row
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`include "uart_flow_defs.svh"

// small transmit fifo, back-pressure on the write side
module tx_byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic [$clog2(D):0] o_count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // storage words
  logic [AW-1:0] wr_ptr_r; // next write slot
  logic [AW-1:0] rd_ptr_r; // next read slot
  logic [AW:0] count_r; // words held
  logic push;
  logic pop;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  // full compare at count width: the pointer width would wrap depth to zero
  assign o_in_ready = (count_r != (AW+1)'(D));
  assign o_out_valid = (count_r != '0);
  assign o_out_data = mem[rd_ptr_r];
  assign o_count = count_r;
  // storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
      end
      if (push && !pop) begin
        count_r <= (AW+1)'(count_r + 1'b1);
      end else if (pop && !push) begin
        count_r <= (AW+1)'(count_r - 1'b1);
      end
    end
  end
endmodule : tx_byte_fifo

module uart_rx_start_and_flow_ctrl (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire uart_flow_pkg::avm_req_t i_bus,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_rx_pin,
  input wire logic [5:0] i_rx_level,
  input wire logic i_cts_n,
  output logic o_rts_n,
  output logic o_serial_tx_pin
);
  logic [1:0] rst_sync_r; // reset release synchroniser
  logic rst_n; // internal reset
  logic [31:0] line_ctrl_r; // serial_line_control
  logic [1:0] rx_trigger_level_r; // receive trigger setting
  logic [15:0] sample_div_r; // sampling tick divisor
  logic [15:0] div_cnt_r; // divider counter
  logic tick_r; // one-cycle sampling tick
  logic wait_r; // waitrequest flop
  logic [31:0] rdata_r; // read data flop
  logic [7:0] start_cnt_r; // accepted start bits
  logic [7:0] glitch_cnt_r; // discarded edges
  logic rts_n_r; // request-to-send pin flop
  logic tx_pin_r; // transmit pin flop
  uart_flow_pkg::rx_state_t rx_state_r;
  uart_flow_pkg::tx_state_t tx_state_r;
  logic rx_prev_r; // previous line level for edge detect
  logic [3:0] rcnt_r; // ticks since edge
  logic [3:0] rbits_r; // bit times since start
  logic [2:0] qual_r; // three qualification samples
  logic [3:0] tcnt_r; // tx tick within bit
  logic [3:0] tbits_r; // tx bits left
  logic [9:0] tshift_r; // tx frame shift
  logic [5:0] high_watermark; // current high watermark
  logic [5:0] low_watermark; // current low watermark
  logic req; // a request is pending
  logic tx_wr; // request is a tx data write
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;
  logic [3:0] fifo_count;
  logic bit_tick; // last tick of a bit
  logic cts_halt; // transmit held off
  logic rx_votes_low; // two of three samples low

  assign rst_n = rst_sync_r[1];
  assign req = i_bus.read || i_bus.write;
  assign tx_wr = i_bus.write && (i_bus.address == `OFS_TX_DATA);
  assign bit_tick = tick_r && (tcnt_r == `TICK_LAST);
  assign cts_halt = line_ctrl_r[`LC_CTS_EN] && i_cts_n;
  assign fifo_pop = (tx_state_r == uart_flow_pkg::TX_IDLE) && bit_tick && !cts_halt;
  assign rx_votes_low = (qual_r[0] + qual_r[1] + qual_r[2]) <= 2'd1;
  assign o_readdata = rdata_r;
  assign o_waitrequest = wait_r;
  assign o_rts_n = rts_n_r;
  assign o_serial_tx_pin = tx_pin_r;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // watermark row from trigger setting
  always_comb begin
    case (rx_trigger_level_r)
      2'h0: begin high_watermark = `HWM_T1; low_watermark = `LWM_T1; end
      2'h1: begin high_watermark = `HWM_T8; low_watermark = `LWM_T8; end
      2'h2: begin high_watermark = `HWM_T16; low_watermark = `LWM_T16; end
      default: begin high_watermark = `HWM_T24; low_watermark = `LWM_T24; end
    endcase
  end

  // bus handshake: answer one cycle after request; tx writes wait for room
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else if (req && wait_r && (!tx_wr || fifo_ready)) begin
      wait_r <= 1'b0;
      if (i_bus.address == `OFS_LINE_CTRL) begin
        rdata_r <= line_ctrl_r;
      end else if (i_bus.address == `OFS_FIFO_CTRL) begin
        rdata_r <= {24'h0, rx_trigger_level_r, 6'h0};
      end else if (i_bus.address == `OFS_SAMPLE_DIV) begin
        rdata_r <= {16'h0, sample_div_r};
      end else if (i_bus.address == `OFS_STATUS) begin
        rdata_r <= {10'h0, rts_n_r, (tx_state_r == uart_flow_pkg::TX_SEND),
                    fifo_count, glitch_cnt_r, start_cnt_r};
      end else begin
        rdata_r <= 32'h0; // unmapped and write-only read zero
      end
    end else begin
      wait_r <= 1'b1;
    end
  end

  // register writes take effect at the edge with waitrequest low
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_ctrl_r <= `LC_RESET;
      rx_trigger_level_r <= 2'h0;
      sample_div_r <= 16'h0;
    end else if (i_bus.write && !wait_r) begin
      if (i_bus.address == `OFS_LINE_CTRL) begin
        line_ctrl_r <= i_bus.writedata & `LC_RW_MASK;
      end else if (i_bus.address == `OFS_FIFO_CTRL) begin
        rx_trigger_level_r <= i_bus.writedata[`FC_TRIG_HI:`FC_TRIG_LO];
      end else if (i_bus.address == `OFS_SAMPLE_DIV) begin
        sample_div_r <= i_bus.writedata[15:0];
      end
    end
  end

  // sampling tick divider, a tick every divisor+1 clocks
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= 16'h0;
      tick_r <= 1'b0;
    end else if (div_cnt_r >= sample_div_r) begin
      div_cnt_r <= 16'h0;
      tick_r <= 1'b1;
    end else begin
      div_cnt_r <= 16'(div_cnt_r + 1'b1);
      tick_r <= 1'b0;
    end
  end

  // start bit qualification on the receive line
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_r <= uart_flow_pkg::RX_IDLE;
      rx_prev_r <= 1'b1;
      rcnt_r <= 4'h0;
      rbits_r <= 4'h0;
      qual_r <= 3'h7;
      start_cnt_r <= 8'h0;
      glitch_cnt_r <= 8'h0;
    end else begin
      rx_prev_r <= i_rx_pin;
      case (rx_state_r)
        uart_flow_pkg::RX_IDLE: begin
          // edge counts only from a line seen high
          if (rx_prev_r && !i_rx_pin) begin
            rx_state_r <= uart_flow_pkg::RX_QUAL;
            rcnt_r <= 4'h0;
            qual_r <= 3'h7;
          end
        end
        uart_flow_pkg::RX_QUAL: begin
          if (tick_r) begin
            rcnt_r <= 4'(rcnt_r + 1'b1);
            if (rcnt_r >= `QUAL_FIRST && rcnt_r <= `QUAL_LAST) begin
              qual_r <= {qual_r[1:0], i_rx_pin};
            end
          end
          if (tick_r && rcnt_r > `QUAL_LAST) begin
            if (rx_votes_low) begin
              rx_state_r <= uart_flow_pkg::RX_FRAME;
              rbits_r <= 4'h0;
              start_cnt_r <= 8'(start_cnt_r + 1'b1);
            end else begin
              rx_state_r <= uart_flow_pkg::RX_IDLE;
              glitch_cnt_r <= 8'(glitch_cnt_r + 1'b1);
            end
          end
        end
        uart_flow_pkg::RX_FRAME: begin
          // ride out the frame so data edges are not starts
          if (tick_r) begin
            rcnt_r <= 4'(rcnt_r + 1'b1);
            if (rcnt_r == `TICK_LAST) begin
              rbits_r <= 4'(rbits_r + 1'b1);
            end
          end
          if (rbits_r >= `RX_STOP_BIT && i_rx_pin) begin
            rx_state_r <= uart_flow_pkg::RX_IDLE;
          end
        end
        default: rx_state_r <= uart_flow_pkg::RX_IDLE;
      endcase
    end
  end

  // request-to-send from receive level with hysteresis
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n_r <= 1'b0;
    end else if (!line_ctrl_r[`LC_RTS_EN]) begin
      rts_n_r <= 1'b0;
    end else if (i_rx_level >= high_watermark) begin
      rts_n_r <= 1'b1;
    end else if (i_rx_level < low_watermark) begin
      rts_n_r <= 1'b0;
    end
  end

  tx_byte_fifo #(.W(8), .D(`TX_FIFO_DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_in_valid(tx_wr && !wait_r),
    .o_in_ready(fifo_ready),
    .i_in_data(i_bus.writedata[7:0]),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data),
    .o_count(fifo_count)
  );

  // transmitter: cts checked only between characters
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_r <= uart_flow_pkg::TX_IDLE;
      tcnt_r <= 4'h0;
      tbits_r <= 4'h0;
      tshift_r <= 10'h3ff;
    end else begin
      if (tick_r) begin
        tcnt_r <= 4'(tcnt_r + 1'b1);
      end
      case (tx_state_r)
        uart_flow_pkg::TX_IDLE: begin
          if (fifo_pop && fifo_valid) begin
            tx_state_r <= uart_flow_pkg::TX_SEND;
            tshift_r <= {1'b1, fifo_data, 1'b0};
            tbits_r <= 4'h9;
          end
        end
        uart_flow_pkg::TX_SEND: begin
          if (bit_tick) begin
            tshift_r <= {1'b1, tshift_r[9:1]};
            tbits_r <= 4'(tbits_r - 1'b1);
            if (tbits_r == 4'h0) begin
              tx_state_r <= uart_flow_pkg::TX_IDLE;
            end
          end
        end
        default: tx_state_r <= uart_flow_pkg::TX_IDLE;
      endcase
    end
  end

  // pin: break forces low, idle rests high
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin_r <= 1'b1;
    end else if (line_ctrl_r[`LC_BREAK]) begin
      tx_pin_r <= 1'b0;
    end else if (tx_state_r == uart_flow_pkg::TX_SEND) begin
      tx_pin_r <= tshift_r[0];
    end else begin
      tx_pin_r <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  chk_idle_line_high: assert property (
    (tx_state_r == uart_flow_pkg::TX_IDLE && !line_ctrl_r[`LC_BREAK])
      ##1 (tx_state_r == uart_flow_pkg::TX_IDLE) |-> o_serial_tx_pin)
    else $error("tx pin not high while idle");
  chk_break_holds_low: assert property (
    line_ctrl_r[`LC_BREAK] |=> !o_serial_tx_pin)
    else $error("break not driving tx low");
  chk_edge_starts_qual: assert property (
    (rx_state_r == uart_flow_pkg::RX_IDLE && rx_prev_r && !i_rx_pin)
      |=> rx_state_r == uart_flow_pkg::RX_QUAL)
    else $error("falling edge missed");
  chk_sample_points: assert property (
    (rx_state_r == uart_flow_pkg::RX_QUAL && tick_r && rcnt_r == `QUAL_FIRST)
      |=> qual_r[0] == $past(i_rx_pin))
    else $error("qualification sample not taken");
  chk_start_accept: assert property (
    (rx_state_r == uart_flow_pkg::RX_QUAL && tick_r && rcnt_r > `QUAL_LAST
      && rx_votes_low) |=> rx_state_r == uart_flow_pkg::RX_FRAME)
    else $error("start bit not accepted");
  chk_glitch_drop: assert property (
    (rx_state_r == uart_flow_pkg::RX_QUAL && tick_r && rcnt_r > `QUAL_LAST
      && !rx_votes_low) |=> rx_state_r == uart_flow_pkg::RX_IDLE
      && glitch_cnt_r == $past(glitch_cnt_r) + 8'h1)
    else $error("glitch not discarded");
  chk_cts_halts_tx: assert property (
    (tx_state_r == uart_flow_pkg::TX_IDLE && cts_halt)
      |=> tx_state_r == uart_flow_pkg::TX_IDLE)
    else $error("tx started while cts high");
  chk_cts_ignored: assert property (
    (tx_state_r == uart_flow_pkg::TX_IDLE && !line_ctrl_r[`LC_CTS_EN]
      && bit_tick && fifo_valid) |=> tx_state_r == uart_flow_pkg::TX_SEND)
    else $error("tx not started with cts disabled");
  chk_rts_high_mark: assert property (
    (line_ctrl_r[`LC_RTS_EN] && i_rx_level >= high_watermark) |=> o_rts_n)
    else $error("rts not deasserted at high mark");
  chk_rts_low_mark: assert property (
    (line_ctrl_r[`LC_RTS_EN] && i_rx_level < low_watermark) |=> !o_rts_n)
    else $error("rts not asserted below low mark");
  chk_rts_disabled: assert property (
    !line_ctrl_r[`LC_RTS_EN] |=> !o_rts_n)
    else $error("rts moved with flow control off");
  chk_top_watermark: assert property (
    rx_trigger_level_r == 2'h3 |-> high_watermark == `HWM_T24 && low_watermark == `LWM_T24)
    else $error("wrong watermark row");
endmodule : uart_rx_start_and_flow_ctrl

// File: dv/uart_link_partner.sv
// remote end of the serial link: drives the receive line and clear-to-send,
// and decodes whatever the device puts on its transmit line
module uart_link_partner (
  input wire logic i_clk,
  input wire logic i_tx_line,
  output logic o_rx_line,
  output logic o_cts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 16; // clocks per bit with divisor 0
  logic [7:0] got[$]; // bytes decoded from the device
  logic [7:0] sh; // decode shift register
  initial begin
    o_rx_line = 1'b1; // line rests high between frames
    o_cts_n = 1'b0;
  end
  // one whole frame: low start, eight bits lsb first, high stop
  task automatic send_frame(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_rx_line <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i-1]);
      repeat (BIT - 1) @(posedge i_clk);
    end
  endtask : send_frame
  // short low pulse, then back to idle high
  task automatic glitch(input int n);
    @(posedge i_clk);
    o_rx_line <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_rx_line <= 1'b1;
  endtask : glitch
  // clear-to-send level; high asks the device to hold off
  task automatic hold_tx(input logic v);
    o_cts_n <= v;
  endtask : hold_tx
  // sample mid bit; a break also decodes as a zero byte, bench discards it
  initial forever begin
    @(negedge i_tx_line);
    repeat (BIT / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_clk);
      sh = {i_tx_line, sh[7:1]};
    end
    got.push_back(sh);
  end
endmodule : uart_link_partner

// File: dv/uart_rx_start_and_flow_ctrl_bench.sv
`include "uart_flow_defs.svh"

module uart_rx_start_and_flow_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk;
  logic i_rstn;
  uart_flow_pkg::avm_req_t req; // held by the bus task only
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic rx_line;
  logic [5:0] rx_level; // fill level seen by rts logic
  logic cts_n;
  logic o_rts_n;
  logic tx_line;
  int errors;
  int checked;
  int seed;
  int starts; // expected accepted starts
  int glitches; // expected discarded edges
  logic [31:0] q; // last read data
  logic [7:0] b;
  logic [7:0] sent[$]; // bytes handed to the transmitter
  logic e; // expected rts_n
  logic [5:0] lv;

  uart_rx_start_and_flow_ctrl u_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_bus(req), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_rx_pin(rx_line), .i_rx_level(rx_level),
    .i_cts_n(cts_n), .o_rts_n(o_rts_n), .o_serial_tx_pin(tx_line)
  );
  uart_link_partner u_link (
    .i_clk(i_clk), .i_tx_line(tx_line), .o_rx_line(rx_line), .o_cts_n(cts_n)
  );

  // free-running 10 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // one bus cycle; a spare edge first so release and raise never share a step
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    req <= '{read: rd, write: !rd, address: a, writedata: d};
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0) begin
      n++;
      if (n > 3000) begin
        errors++;
        report_and_stop();
      end
      @(posedge i_clk);
    end
    q = o_readdata;
    req <= '0;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b1, a, 32'h0);
    check(q, exp, what);
  endtask : rd_chk

  // wait for n decoded bytes, then compare against what was sent
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (u_link.got.size() < n && k < 4000) begin
      k++;
      @(posedge i_clk);
    end
    check(32'(u_link.got.size()), 32'(n), "tx byte count");
    for (int i = 0; i < n && i < u_link.got.size(); i++) check(u_link.got[i], sent[i], "tx byte");
    u_link.got.delete();
    sent.delete();
  endtask : wait_got

  function automatic logic [5:0] high_watermark(input logic [1:0] t);
    return t == 2'h0 ? `HWM_T1 : t == 2'h1 ? `HWM_T8 : t == 2'h2 ? `HWM_T16 : `HWM_T24;
  endfunction : high_watermark

  function automatic logic [5:0] low_watermark(input logic [1:0] t);
    return t == 2'h0 ? `LWM_T1 : t == 2'h1 ? `LWM_T8 : t == 2'h2 ? `LWM_T16 : `LWM_T24;
  endfunction : low_watermark

  // hysteresis between the two thresholds
  function automatic logic next_rts(input logic cur, input logic [5:0] l, input logic [1:0] t);
    if (l >= high_watermark(t)) return 1'b1;
    if (l < low_watermark(t)) return 1'b0;
    return cur;
  endfunction : next_rts

  // status as expected while transmitter idle and rts asserted
  function automatic logic [31:0] stat(input logic [3:0] fifo);
    return {12'h0, fifo, glitches[7:0], starts[7:0]};
  endfunction : stat

  // main sequence
  initial begin
    seed = 32'h31f400f6;
    errors = 0;
    checked = 0;
    starts = 0;
    glitches = 0;
    req = '0;
    rx_level = 6'h00;
    i_rstn = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clk);
    // reset values, read-only and unmapped places
    rd_chk(`OFS_LINE_CTRL, `LC_RESET, "line control reset");
    rd_chk(`OFS_SAMPLE_DIV, 32'h0, "divisor reset");
    bus(1'b0, `OFS_STATUS, 32'hffffffff);
    rd_chk(`OFS_STATUS, stat(4'h0), "status reset");
    bus(1'b0, 8'h24, 32'hffffffff);
    rd_chk(8'h20, 32'h0, "unmapped read");
    // break rides on a full write; hold it well past a frame time
    bus(1'b0, `OFS_LINE_CTRL, 32'hffffffff);
    rd_chk(`OFS_LINE_CTRL, `LC_RW_MASK, "line control mask");
    for (int i = 0; i < 200; i++) begin
      @(posedge i_clk);
      check(tx_line, 1'b0, "break level");
    end
    bus(1'b0, `OFS_LINE_CTRL, `LC_RESET);
    repeat (2) @(posedge i_clk);
    check(tx_line, 1'b1, "idle after break");
    u_link.got.delete();
    $display("test registers and break done");
    // short pulses must be thrown away, long lows accepted
    for (int i = 0; i < 2; i++) begin
      u_link.glitch(2 + 3 * i);
      repeat (30) @(posedge i_clk);
      glitches++;
    end
    u_link.glitch(12);
    repeat (160) @(posedge i_clk);
    starts++;
    for (int i = 0; i < 4; i++) begin
      b = (i == 0) ? 8'h55 : 8'($random(seed));
      u_link.send_frame(b);
      repeat (40) @(posedge i_clk);
      starts++;
    end
    rd_chk(`OFS_STATUS, stat(4'h0), "start and glitch counts");
    $display("test start qualification done");
    // flow control off: clear-to-send high is ignored
    u_link.hold_tx(1'b1);
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      sent.push_back(b);
      bus(1'b0, `OFS_TX_DATA, {24'h0, b});
    end
    wait_got(3);
    // flow control on: nothing leaves, fifo fills and refuses
    // flow-control pins taken as already routed to this port by software
    bus(1'b0, `OFS_LINE_CTRL, 32'h0000_0203);
    for (int i = 0; i < 8; i++) begin
      b = 8'($random(seed));
      sent.push_back(b);
      bus(1'b0, `OFS_TX_DATA, {24'h0, b});
    end
    repeat (300) @(posedge i_clk);
    check(32'(u_link.got.size()), 32'h0, "sent while halted");
    rd_chk(`OFS_STATUS, stat(4'h8), "fifo full count");
    b = 8'($random(seed));
    sent.push_back(b);
    fork
      bus(1'b0, `OFS_TX_DATA, {24'h0, b});
      begin
        repeat (40) @(posedge i_clk);
        check(o_waitrequest, 1'b1, "full fifo took a write");
        u_link.hold_tx(1'b0);
      end
    join
    wait_got(9);
    $display("test transmit flow control done");
    // rts watermarks for every trigger setting
    bus(1'b0, `OFS_LINE_CTRL, 32'h0000_0103);
    for (int t = 0; t < 4; t++) begin
      bus(1'b0, `OFS_FIFO_CTRL, {24'h0, 2'(t), 6'h0});
      e = 1'b0;
      for (int k = 0; k < 25; k++) begin
        case (k)
          0: lv = 6'h00;
          1: lv = high_watermark(2'(t)) - 6'h01;
          2: lv = high_watermark(2'(t));
          3: lv = low_watermark(2'(t));
          4: lv = low_watermark(2'(t)) - 6'h01;
          default: lv = 6'($random(seed));
        endcase
        e = next_rts(e, lv, 2'(t));
        @(posedge i_clk);
        rx_level <= lv;
        repeat (2) @(posedge i_clk);
        check(o_rts_n, e, "rts level");
      end
    end
    // flow control off: level no longer steers rts
    bus(1'b0, `OFS_LINE_CTRL, `LC_RESET);
    @(posedge i_clk);
    rx_level <= 6'h3f;
    repeat (2) @(posedge i_clk);
    check(o_rts_n, 1'b0, "rts while disabled");
    $display("test receive flow control done");
    report_and_stop();
  end
endmodule : uart_rx_start_and_flow_ctrl_bench
